// >>> shared/dual_cc_map.vh
`ifndef DUAL_CC_MAP_VH
`define DUAL_CC_MAP_VH

// ==========================================================
// register byte offsets on the bus
`define CC_OFS_MODE_CONTROL 8'h00
`define CC_OFS_CAPTURE_ONE 8'h04
`define CC_OFS_CAPTURE_TWO 8'h08
`define CC_OFS_COMPARE_ONE 8'h0C
`define CC_OFS_COMPARE_TWO 8'h10
`define CC_OFS_FLAGS 8'h14
`define CC_OFS_PORT 8'h18
`define CC_OFS_STATUS 8'h1C

// ==========================================================
// field positions
`define CC_SET_ONE_MODE_LSB 0
`define CC_SET_TWO_MODE_LSB 4
`define CC_FLAG_OVERFLOW_BIT 0
`define CC_FLAG_SET_ONE_BIT 2
`define CC_FLAG_SET_TWO_BIT 3
`define CC_PORT_DATA_BIT 0
`define CC_PORT_DIR_BIT 1
`define CC_STATUS_PIN_BIT 2

// ==========================================================
// reset values
`define CC_MODE_CONTROL_RESET 8'h00
`define CC_COMPARE_RESET 16'h0000
`define CC_CAPTURE_RESET 16'h0000
`define CC_PORT_DATA_RESET 1'b0
`define CC_PORT_DIR_RESET 1'b1

// ==========================================================
// mode field codes
`define CC_MODE_CAP_FALL 4'h4
`define CC_MODE_CAP_RISE 4'h5
`define CC_MODE_CAP_RISE4 4'h6
`define CC_MODE_CAP_RISE16 4'h7
`define CC_MODE_CMP_SET 4'h8
`define CC_MODE_CMP_CLEAR 4'h9
`define CC_MODE_CMP_TOGGLE 4'hA
`define CC_MODE_CMP_RESERVED 4'hB
`define CC_MODE_CMP_TRIGGER 4'hF

`endif

// >>> verilog/cc_pin_sync.v
`timescale 1ns/10ps

// ==========================================================
// three-stage synchroniser: level moves once stages two and three agree
module cc_pin_sync
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // raw pin and clean level
  input wire pin_i,
  output reg level_o
);

  reg stage_one;
  reg stage_two;
  reg stage_three;

  // shift chain, first stage read only by the second
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage_one <= 1'b0;
      stage_two <= 1'b0;
      stage_three <= 1'b0;
      level_o <= 1'b0;
    end
    else
    begin
      stage_one <= pin_i;
      stage_two <= stage_one;
      stage_three <= stage_two;
      if (stage_two == stage_three)
        level_o <= stage_three; // R21
    end
  end

endmodule

// >>> verilog/cc_edge_prescaler.v
`timescale 1ns/10ps

// ==========================================================
// edge qualifier and prescaler for one register set
module cc_edge_prescaler
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // set is off or not capturing
  input wire clear_i,
  // low two mode bits select the event kind
  input wire [1:0] kind_i,
  // detected pin edges
  input wire rise_i,
  input wire fall_i,
  // qualified capture event, one cycle
  output wire event_o
);

  reg [3:0] count;

  // counter only moves on rising edges and is cleared when not capturing
  always @(posedge clk_i)
  begin
    if (rst_i)
      count <= 4'h0; // R6
    else if (clear_i)
      count <= 4'h0; // R6
    else if (rise_i)
      count <= count + 4'h1; // R7
  end

  // kind: 00 falling, 01 rising, 10 fourth rising, 11 sixteenth rising
  assign event_o = !clear_i && ((kind_i == 2'b00 && fall_i) ||
                                (kind_i == 2'b01 && rise_i) ||
                                (kind_i == 2'b10 && rise_i && count[1:0] == 2'b11) ||
                                (kind_i == 2'b11 && rise_i && count == 4'hF)); // R2

endmodule

// >>> verilog/dual_capture_compare.v
// What this block does
// R1: capture latches 16-bit timebase on pin event
// R2: mode 0100 fall, 0101 rise, 0110/0111 prescaled
// R3: set two mode bits 7-4, one 3-0
// R4: capture sets flag bit 2 or 3
// R5: new capture overwrites unread value
// R6: prescaler cleared when off, non-capture, reset
// R7: prescale change keeps partial count
// R8: software disables set before prescale change
// R9: software masks interrupt during mode change
// R10: port write changing output pin captures
// R11: compare value matched against timebase, flags
// R12: 1000 high, 1001 low, 1010 toggle
// R13: clearing mode resets compare latch default
// R14: 11xx match only sets flag
// R15: 1111 also emits conversion trigger pulse
// R16: trigger never clears the timebase
// R17: trigger never sets overflow flag
// R18: mode 00xx turns set off, resets
// R19: software clocks timebase from instruction clock
// R20: software sets pin direction per mode
// R21: capture input synchronised, edges from samples
`timescale 1ns/10ps
`include "dual_cc_map.vh"

module dual_capture_compare
#(
  parameter ADR_WIDTH = 8
)
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_WIDTH-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // shared timebase count
  input wire [15:0] timebase_i,
  // capture input pin, two-way
  input wire cap_pin_i,
  output reg cap_pin_o,
  output reg cap_pin_oe_o,
  // compare outputs, index 0 is set one
  output reg [1:0] compare_out_o,
  // event flags toward the interrupt logic
  output reg [1:0] event_flag_o,
  // conversion trigger pulses toward the converter
  output reg [1:0] special_event_o
);

  // ==========================================================
  // decode helpers

  // merge the low two byte lanes into a 16-bit value
  function [15:0] lane_merge;
    input [15:0] old_value;
    input [31:0] data;
    input [3:0] sel;
    begin
      lane_merge = old_value;
      if (sel[0])
        lane_merge[7:0] = data[7:0];
      if (sel[1])
        lane_merge[15:8] = data[15:8];
    end
  endfunction

  // mode is one of the capture codes
  function is_capture;
    input [3:0] mode;
    begin
      is_capture = (mode[3:2] == 2'b01);
    end
  endfunction

  // mode drives the compare output latch
  function is_output_compare;
    input [3:0] mode;
    begin
      is_output_compare = (mode == `CC_MODE_CMP_SET) || (mode == `CC_MODE_CMP_CLEAR) ||
                          (mode == `CC_MODE_CMP_TOGGLE);
    end
  endfunction

  // idle level of the compare latch for a mode
  function latch_default;
    input [3:0] mode;
    begin
      latch_default = (mode == `CC_MODE_CMP_CLEAR);
    end
  endfunction

  // ==========================================================
  // state

  reg [7:0] mode_control;
  reg [15:0] compare_value [0:1];
  reg [15:0] capture_value [0:1];
  reg [1:0] compare_latch;
  reg [1:0] compare_entered;
  reg [1:0] match_prev;
  reg port_data;
  reg pin_direction;
  reg source_prev;

  wire pin_level;
  wire request;
  wire do_write;
  wire do_flag_clear;
  wire [1:0] capture_event;
  wire [1:0] match_now;
  wire [3:0] set_mode [0:1];
  wire source_level;
  wire source_rise;
  wire source_fall;
  wire [1:0] flag_clear;
  wire next_port_data;
  wire next_pin_direction;
  reg [31:0] next_read_data;

  // mode fields of both sets
  assign set_mode[0] = mode_control[`CC_SET_ONE_MODE_LSB+3:`CC_SET_ONE_MODE_LSB]; // R3
  assign set_mode[1] = mode_control[`CC_SET_TWO_MODE_LSB+3:`CC_SET_TWO_MODE_LSB]; // R3

  // ==========================================================
  // bus slave

  // a request is taken once, the cycle before ack
  assign request = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign do_write = request && wb_we_i;
  assign do_flag_clear = do_write && (wb_adr_i == `CC_OFS_FLAGS) && wb_sel_i[0];
  assign flag_clear[0] = do_flag_clear && wb_dat_i[`CC_FLAG_SET_ONE_BIT];
  assign flag_clear[1] = do_flag_clear && wb_dat_i[`CC_FLAG_SET_TWO_BIT];

  // ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= request;
  end

  // read mux, unmapped addresses read zero
  always @*
  begin
    next_read_data = 32'h0000_0000;
    case (wb_adr_i)
      `CC_OFS_MODE_CONTROL: next_read_data[7:0] = mode_control;
      `CC_OFS_CAPTURE_ONE: next_read_data[15:0] = capture_value[0];
      `CC_OFS_CAPTURE_TWO: next_read_data[15:0] = capture_value[1];
      `CC_OFS_COMPARE_ONE: next_read_data[15:0] = compare_value[0];
      `CC_OFS_COMPARE_TWO: next_read_data[15:0] = compare_value[1];
      `CC_OFS_FLAGS:
      begin
        next_read_data[`CC_FLAG_SET_ONE_BIT] = event_flag_o[0];
        next_read_data[`CC_FLAG_SET_TWO_BIT] = event_flag_o[1];
        next_read_data[`CC_FLAG_OVERFLOW_BIT] = 1'b0; // R17
      end
      `CC_OFS_PORT:
      begin
        next_read_data[`CC_PORT_DATA_BIT] = port_data;
        next_read_data[`CC_PORT_DIR_BIT] = pin_direction;
      end
      `CC_OFS_STATUS:
      begin
        next_read_data[1:0] = compare_latch;
        next_read_data[`CC_STATUS_PIN_BIT] = pin_level;
      end
      default: next_read_data = 32'h0000_0000;
    endcase
  end

  // read data registered alongside ack
  always @(posedge clk_i)
  begin
    if (rst_i || !(request && !wb_we_i))
      wb_dat_o <= 32'h0000_0000;
    else
      wb_dat_o <= next_read_data;
  end

  // mode control register, byte lane zero
  always @(posedge clk_i)
  begin
    if (rst_i)
      mode_control <= `CC_MODE_CONTROL_RESET;
    else if (do_write && wb_adr_i == `CC_OFS_MODE_CONTROL && wb_sel_i[0])
      mode_control <= wb_dat_i[7:0]; // R3
  end

  // compare values, writable in any mode
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      compare_value[0] <= `CC_COMPARE_RESET;
      compare_value[1] <= `CC_COMPARE_RESET;
    end
    else if (do_write && wb_adr_i == `CC_OFS_COMPARE_ONE)
      compare_value[0] <= lane_merge(compare_value[0], wb_dat_i, wb_sel_i);
    else if (do_write && wb_adr_i == `CC_OFS_COMPARE_TWO)
      compare_value[1] <= lane_merge(compare_value[1], wb_dat_i, wb_sel_i);
  end

  // port data latch and direction bit, next values also feed the pin driver
  assign next_port_data = (do_write && wb_adr_i == `CC_OFS_PORT && wb_sel_i[0]) ? wb_dat_i[`CC_PORT_DATA_BIT] :
                          port_data;
  assign next_pin_direction = (do_write && wb_adr_i == `CC_OFS_PORT && wb_sel_i[0]) ? wb_dat_i[`CC_PORT_DIR_BIT] :
                              pin_direction;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_data <= `CC_PORT_DATA_RESET;
      pin_direction <= `CC_PORT_DIR_RESET;
    end
    else
    begin
      port_data <= next_port_data;
      pin_direction <= next_pin_direction;
    end
  end

  // ==========================================================
  // capture input path

  cc_pin_sync u_pin_sync
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(cap_pin_i),
    .level_o(pin_level)
  );

  // an output pin captures its own driven level, so port writes count
  assign source_level = pin_direction ? pin_level : cap_pin_o; // R10

  // previous sample for edge detection
  always @(posedge clk_i)
  begin
    if (rst_i)
      source_prev <= 1'b0;
    else
      source_prev <= source_level;
  end

  assign source_rise = source_level && !source_prev; // R21
  assign source_fall = !source_level && source_prev; // R21

  // pin driver: set one compare latch owns it in output compare modes
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cap_pin_o <= `CC_PORT_DATA_RESET;
      cap_pin_oe_o <= 1'b0;
    end
    else
    begin
      cap_pin_oe_o <= !next_pin_direction;
      cap_pin_o <= is_output_compare(set_mode[0]) ? compare_latch[0] : next_port_data; // R14
    end
  end

  // ==========================================================
  // per-set capture and compare

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_set
      // prescaler cleared whenever the set is not capturing
      cc_edge_prescaler u_prescaler
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(!is_capture(set_mode[g])),
        .kind_i(set_mode[g][1:0]),
        .rise_i(source_rise),
        .fall_i(source_fall),
        .event_o(capture_event[g])
      );
      // match detected once, on the cycle equality starts
      assign match_now[g] = (set_mode[g][3] == 1'b1) && (set_mode[g] != `CC_MODE_CMP_RESERVED) &&
                            (compare_value[g] == timebase_i); // R11

      // capture register, overwritten by every capture
      always @(posedge clk_i)
      begin
        if (rst_i)
          capture_value[g] <= `CC_CAPTURE_RESET;
        else if (capture_event[g])
          capture_value[g] <= timebase_i; // R1 R5
      end
      // match history; an idle set never matches, so it also clears while off
      always @(posedge clk_i)
      begin
        if (rst_i)
          match_prev[g] <= 1'b0; // R18
        else
          match_prev[g] <= match_now[g];
      end

      // event flag: hardware set wins over software clear
      always @(posedge clk_i)
      begin
        if (rst_i)
          event_flag_o[g] <= 1'b0;
        else if (capture_event[g] || (match_now[g] && !match_prev[g]))
          event_flag_o[g] <= 1'b1; // R4 R11
        else if (flag_clear[g])
          event_flag_o[g] <= 1'b0; // R4
      end

      // compare output latch, independent of the port data latch; mode default loaded once on entry only,
      // so a cleared flag never brings a clear-on-match latch back to one
      always @(posedge clk_i)
      begin
        if (rst_i || !is_output_compare(set_mode[g]))
        begin
          compare_latch[g] <= 1'b0; // R13 R18
          compare_entered[g] <= 1'b0;
        end
        else
        begin
          compare_entered[g] <= 1'b1;
          if (match_now[g] && !match_prev[g])
          begin
            case (set_mode[g])
              `CC_MODE_CMP_SET: compare_latch[g] <= 1'b1; // R12
              `CC_MODE_CMP_CLEAR: compare_latch[g] <= 1'b0; // R12
              `CC_MODE_CMP_TOGGLE: compare_latch[g] <= !compare_latch[g]; // R12
              default: compare_latch[g] <= compare_latch[g];
            endcase
          end
          else if (!compare_entered[g])
            compare_latch[g] <= latch_default(set_mode[g]); // R13
        end
      end

      // compare pin follows the latch; trigger pulse only in 1111, the timebase is never touched here
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          compare_out_o[g] <= 1'b0;
          special_event_o[g] <= 1'b0;
        end
        else
        begin
          compare_out_o[g] <= compare_latch[g];
          special_event_o[g] <= (set_mode[g] == `CC_MODE_CMP_TRIGGER) && match_now[g] &&
                                !match_prev[g]; // R15 R16 R17
        end
      end
    end
  endgenerate

endmodule

// >>> testbench/cc_checker_props.sv
`timescale 1ns/10ps
`include "dual_cc_map.vh"

// ==========================================================
// bus and event checks
module cc_checker
#(
  parameter ADR_WIDTH = 8
)
(
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [ADR_WIDTH-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // events
  input wire [1:0] compare_out_o,
  input wire [1:0] event_flag_o,
  input wire [1:0] special_event_o,
  input wire cap_pin_oe_o
);
  // flag register requests on their taking edge
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire on_flags = wb_adr_i == `CC_OFS_FLAGS;
  wire clr_one = req && wb_we_i && on_flags && wb_sel_i[0] && wb_dat_i[`CC_FLAG_SET_ONE_BIT];
  wire clr_two = req && wb_we_i && on_flags && wb_sel_i[0] && wb_dat_i[`CC_FLAG_SET_TWO_BIT];
  wire rd_flags = !wb_we_i && on_flags;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_follows_req: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_flag_one_sticky: assert property ($fell(event_flag_o[0]) |-> $past(clr_one) || $past(rst_i))
    else $error("flag one dropped without clear");
  a_flag_two_sticky: assert property (event_flag_o[1] && !clr_two |=> event_flag_o[1])
    else $error("flag two dropped without clear");
  a_trig_one_flag: assert property (special_event_o[0] |-> event_flag_o[0] ##1 !special_event_o[0])
    else $error("trigger one without flag or too long");
  a_trig_two_pulse: assert property (special_event_o[1] |=> !special_event_o[1])
    else $error("trigger two longer than one cycle");
  a_overflow_zero: assert property (wb_ack_o && $past(rd_flags) |-> !wb_dat_o[`CC_FLAG_OVERFLOW_BIT])
    else $error("overflow bit read as one");
  a_reset_quiet: assert property ($past(rst_i) |-> !cap_pin_oe_o && event_flag_o == 2'b00 && compare_out_o == 2'b00)
    else $error("outputs not idle after reset");

  c_trig_one: cover property (special_event_o[0]);
  c_flag_two: cover property ($rose(event_flag_o[1]));
  c_latch_fall: cover property ($fell(compare_out_o[0]));
endmodule

bind dual_capture_compare cc_checker #(.ADR_WIDTH(ADR_WIDTH)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .compare_out_o(compare_out_o), .event_flag_o(event_flag_o),
  .special_event_o(special_event_o), .cap_pin_oe_o(cap_pin_oe_o));

// >>> testbench/cc_pin_source.sv
`timescale 1ns/10ps

// ==========================================================
// external source on the capture pin
module cc_pin_source
(
  // clock
  input wire clk_i,
  // device side of the pin
  input wire cap_pin_o,
  input wire cap_pin_oe_o,
  // resolved pin level
  output wire cap_pin_i
);
  reg level = 1'b0;
  // device drive wins while its enable is high
  assign cap_pin_i = cap_pin_oe_o ? cap_pin_o : level;
  // new level, held long enough for the synchroniser
  task set_level(input v);
    begin
      @(posedge clk_i);
      level <= v;
      repeat (8) @(posedge clk_i);
    end
  endtask
endmodule

// >>> testbench/testbench.sv
`timescale 1ns/10ps

// ==========================================================
// register-level tests
module testbench;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'h3;
  reg [3:0] lanes = 4'h3;
  reg [31:0] wb_dat_i = 32'h0000_0000;
  reg [15:0] timebase_i = 16'h0000;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, cap_pin_i, cap_pin_o, cap_pin_oe_o;
  wire [1:0] compare_out_o, event_flag_o, special_event_o;
  integer num_errors = 0;
  integer total_checks = 0;
  integer p0, p1;

  // clock
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  dual_capture_compare u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .timebase_i(timebase_i), .cap_pin_i(cap_pin_i), .cap_pin_o(cap_pin_o),
    .cap_pin_oe_o(cap_pin_oe_o), .compare_out_o(compare_out_o), .event_flag_o(event_flag_o),
    .special_event_o(special_event_o));
  cc_pin_source u_src (.clk_i(clk_i), .cap_pin_o(cap_pin_o), .cap_pin_oe_o(cap_pin_oe_o), .cap_pin_i(cap_pin_i));

  // ==========================================================
  // helpers
  task complete_run;
    begin
      if (num_errors == 0 && total_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  task check(input [15:0] v, input [15:0] e);
    begin
      total_checks = total_checks + 1;
      if (v !== e)
      begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED %0t: got %h expected %h", $time, v, e);
      end
    end
  endtask

  task xfer(input [7:0] a, input w, input [15:0] d, output [15:0] q);
    integer n;
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= lanes;
      wb_dat_i <= {16'h0000, d};
      n = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
        @(posedge clk_i);
        n = n + 1;
      end
      q = wb_dat_o[15:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1)
      begin
        num_errors = num_errors + 1;
        complete_run;
      end
    end
  endtask

  task wr(input [7:0] a, input [15:0] d);
    reg [15:0] q;
    begin
      xfer(a, 1'b1, d, q);
    end
  endtask

  task rd(input [7:0] a, input [15:0] e);
    reg [15:0] q;
    begin
      xfer(a, 1'b0, 16'h0000, q);
      check(q, e);
    end
  endtask

  task cmp(input [1:0] e);
    begin
      check({14'h0000, compare_out_o}, {14'h0000, e});
    end
  endtask

  task rises(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
      begin
        u_src.set_level(1'b0);
        u_src.set_level(1'b1);
      end
    end
  endtask

  // one equality run of the timebase against 0100
  task match;
    begin
      timebase_i <= 16'h0100;
      repeat (4) @(posedge clk_i);
      timebase_i <= 16'h0000;
      repeat (4) @(posedge clk_i);
    end
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 16'h0000);
    wr(8'h00, 16'h0045);
    rd(8'h00, 16'h0045);
    timebase_i <= 16'h1234;
    u_src.set_level(1'b1);
    rd(8'h04, 16'h1234);
    rd(8'h08, 16'h0000);
    timebase_i <= 16'h5678;
    u_src.set_level(1'b0);
    rd(8'h08, 16'h5678);
    rd(8'h04, 16'h1234);
    rd(8'h14, 16'h000C);
    timebase_i <= 16'h2222;
    u_src.set_level(1'b1);
    rd(8'h04, 16'h2222);
    wr(8'h14, 16'h000C);
    rd(8'h14, 16'h0000);
    wr(8'h00, 16'h0000);
    wr(8'h00, 16'h0006);
    rises(3);
    rd(8'h14, 16'h0000);
    rises(1);
    rd(8'h14, 16'h0004);
    wr(8'h14, 16'h0004);
    rises(2);
    wr(8'h00, 16'h0007);
    rises(9);
    rd(8'h14, 16'h0000);
    rises(1);
    rd(8'h14, 16'h0004);
    wr(8'h00, 16'h0005);
    wr(8'h14, 16'h0004);
    timebase_i <= 16'h0ABC;
    wr(8'h18, 16'h0001);
    wr(8'h18, 16'h0000);
    wr(8'h18, 16'h0001);
    repeat (8) @(posedge clk_i);
    check({15'h0000, cap_pin_oe_o}, 16'h0001);
    rd(8'h04, 16'h0ABC);
    wr(8'h18, 16'h0002);
    wr(8'h0C, 16'h0100);
    timebase_i <= 16'h0000;
    wr(8'h00, 16'h0008);
    wr(8'h14, 16'h000C);
    cmp(2'b00);
    match;
    cmp(2'b01);
    rd(8'h14, 16'h0004);
    wr(8'h00, 16'h0000);
    wr(8'h14, 16'h0004);
    cmp(2'b00);
    wr(8'h00, 16'h0009);
    repeat (4) @(posedge clk_i);
    cmp(2'b01);
    match;
    cmp(2'b00);
    wr(8'h14, 16'h0004);
    repeat (4) @(posedge clk_i);
    cmp(2'b00);
    wr(8'h00, 16'h0000);
    wr(8'h00, 16'h000A);
    match;
    cmp(2'b01);
    match;
    cmp(2'b00);
    wr(8'h00, 16'h0000);
    wr(8'h14, 16'h0004);
    wr(8'h00, 16'h000B);
    match;
    rd(8'h14, 16'h0000);
    wr(8'h00, 16'h000C);
    match;
    rd(8'h14, 16'h0004);
    cmp(2'b00);
    wr(8'h0C, 16'h0200);
    wr(8'h10, 16'h0200);
    wr(8'h00, 16'h00FF);
    wr(8'h14, 16'h000C);
    p0 = 0;
    p1 = 0;
    timebase_i <= 16'h0200;
    repeat (6)
    begin
      @(posedge clk_i);
      p0 = p0 + special_event_o[0];
      p1 = p1 + special_event_o[1];
    end
    check({8'h00, p1[3:0], p0[3:0]}, 16'h0011);
    rd(8'h14, 16'h000C);
    lanes = 4'h2;
    wr(8'h14, 16'h000C);
    rd(8'h14, 16'h000C);
    lanes = 4'h1;
    wr(8'h0C, 16'hFFAA);
    lanes = 4'h3;
    rd(8'h0C, 16'h02AA);
    wr(8'h00, 16'h0000);
    wr(8'h10, 16'h0100);
    wr(8'h00, 16'h0080);
    match;
    cmp(2'b10);
    rd(8'h20, 16'h0000);
    complete_run;
  end
endmodule
